/* File: logic/byte_wide_io_ports.sv */
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
// Summary of operation
// - data writes always update the output latch, even for input pins.
// - data reads give latch for output bits, sampled pin for inputs.
// - open-drain output bits read back the sampled pin level.
// - port C implements bits 2..0 only; upper bits read zero, writes ignored.
// - direction bit 0 means input, 1 means output; software read/write.
// - reset clears all data and direction registers; all pins inputs.
// - port B pins 5..7 drive external interrupt lines six..eight when enabled.
// - usb select set makes port C pin 2 output the usb transmit indication.
module byte_wide_io_ports
    import gpio_ports_pkg::*;
#(
    parameter logic [7:0] open_drain_a = 8'h00,
    parameter logic [7:0] open_drain_b = 8'h00,
    parameter logic [2:0] open_drain_c = 3'h0
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // port pins
    input wire logic [7:0] port_a_in,
    output logic [7:0] port_a_out,
    output logic [7:0] port_a_oe_n,
    input wire logic [7:0] port_b_in,
    output logic [7:0] port_b_out,
    output logic [7:0] port_b_oe_n,
    input wire logic [2:0] port_c_in,
    output logic [2:0] port_c_out,
    output logic [2:0] port_c_oe_n,
    // alternate functions
    input wire logic usb_transmitting,
    output logic ext_irq_line_six,
    output logic ext_irq_line_seven,
    output logic ext_irq_line_eight
);
    logic [7:0] a_data_reg, a_data_next, a_dir_reg, a_dir_next;
    logic [7:0] b_data_reg, b_data_next, b_dir_reg, b_dir_next;
    logic [2:0] c_data_reg, c_data_next, c_dir_reg, c_dir_next;
    logic [7:0] misc_control_reg, misc_control_next;
    logic [7:0] ext_irq_enable_reg, ext_irq_enable_next;
    logic wr_pend_reg, wr_pend_next;
    logic [2:0] wr_idx_reg, wr_idx_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic [7:0] a_oe_n_reg, a_oe_n_next, a_out_reg, a_out_next;
    logic [7:0] b_oe_n_reg, b_oe_n_next, b_out_reg, b_out_next;
    logic [2:0] c_oe_n_reg, c_oe_n_next, c_out_reg, c_out_next;
    logic [2:0] irq_reg, irq_next;
    logic usb_sync1_reg, usb_sync2_reg, usb_sync3_reg;
    logic [18:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_level_reg;
    logic [18:0] pin_level_next;
    logic usb_level_reg, usb_level_next;
    logic [7:0] a_read, b_read;
    logic [2:0] c_read;
    logic take;

    // pins pass three flops; a change counts once stages two and three agree
    always_ff @(posedge clock) begin
        if (reset) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            pin_s3_reg <= '0;
            usb_sync1_reg <= 1'b0;
            usb_sync2_reg <= 1'b0;
            usb_sync3_reg <= 1'b0;
        end else begin
            pin_s1_reg <= {port_c_in, port_b_in, port_a_in};
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            usb_sync1_reg <= usb_transmitting;
            usb_sync2_reg <= usb_sync1_reg;
            usb_sync3_reg <= usb_sync2_reg;
        end
    end

    always_comb begin
        pin_level_next = pin_level_reg;
        for (int i = 0; i < 19; i++) begin
            if (pin_s2_reg[i] == pin_s3_reg[i]) begin
                pin_level_next[i] = pin_s2_reg[i];
            end
        end
        usb_level_next = usb_level_reg;
        if (usb_sync2_reg == usb_sync3_reg) begin
            usb_level_next = usb_sync2_reg;
        end
    end

    // readback mux: open-drain outputs show the pin, not the latch
    always_comb begin
        a_read = (a_dir_reg & ~open_drain_a & a_data_reg)
            | (~(a_dir_reg & ~open_drain_a) & pin_level_reg[7:0]);
        b_read = (b_dir_reg & ~open_drain_b & b_data_reg)
            | (~(b_dir_reg & ~open_drain_b) & pin_level_reg[15:8]);
        c_read = (c_dir_reg & ~open_drain_c & c_data_reg)
            | (~(c_dir_reg & ~open_drain_c) & pin_level_reg[18:16]);
    end

    assign take = hsel && hready && (htrans == htrans_nonseq);

    // zero wait states; write data lands one cycle after the address phase
    always_comb begin
        wr_pend_next = take && hwrite;
        wr_idx_next = haddr[4:2];
        hrdata_next = hrdata_reg;
        a_data_next = a_data_reg;
        a_dir_next = a_dir_reg;
        b_data_next = b_data_reg;
        b_dir_next = b_dir_reg;
        c_data_next = c_data_reg;
        c_dir_next = c_dir_reg;
        misc_control_next = misc_control_reg;
        ext_irq_enable_next = ext_irq_enable_reg;
        if (take && !hwrite) begin
            unique case (haddr[4:2])
                port_a_data_idx: hrdata_next = {24'h00_0000, a_read};
                port_a_direction_idx: hrdata_next = {24'h00_0000, a_dir_reg};
                port_b_data_idx: hrdata_next = {24'h00_0000, b_read};
                port_b_direction_idx: hrdata_next = {24'h00_0000, b_dir_reg};
                port_c_data_idx: hrdata_next = {29'h0000_0000, c_read};
                port_c_direction_idx: hrdata_next = {29'h0000_0000, c_dir_reg};
                misc_control_idx: hrdata_next = {24'h00_0000, misc_control_reg};
                ext_irq_enable_idx: hrdata_next = {24'h00_0000, ext_irq_enable_reg};
            endcase
        end
        if (haddr[31:5] != 27'h000_0000 && take) begin
            hrdata_next = 32'h0000_0000;
            wr_pend_next = 1'b0;
        end
        if (wr_pend_reg) begin
            unique case (wr_idx_reg)
                port_a_data_idx: a_data_next = hwdata[7:0];
                port_a_direction_idx: a_dir_next = hwdata[7:0];
                port_b_data_idx: b_data_next = hwdata[7:0];
                port_b_direction_idx: b_dir_next = hwdata[7:0];
                port_c_data_idx: c_data_next = hwdata[2:0];
                port_c_direction_idx: c_dir_next = hwdata[2:0];
                misc_control_idx: misc_control_next = hwdata[7:0] & 8'h07;
                ext_irq_enable_idx: ext_irq_enable_next = hwdata[7:0];
            endcase
        end
    end

    // pin drivers and interrupt feeds, all registered
    always_comb begin
        a_out_next = a_data_reg;
        a_oe_n_next = ~a_dir_reg;
        b_out_next = b_data_reg;
        b_oe_n_next = ~b_dir_reg;
        for (int i = 0; i < 8; i++) begin
            // open drain only pulls low
            if (open_drain_a[i]) begin
                a_out_next[i] = 1'b0;
                a_oe_n_next[i] = ~(a_dir_reg[i] & ~a_data_reg[i]);
            end
            if (open_drain_b[i]) begin
                b_out_next[i] = 1'b0;
                b_oe_n_next[i] = ~(b_dir_reg[i] & ~b_data_reg[i]);
            end
        end
        c_out_next = c_data_reg;
        c_oe_n_next = ~c_dir_reg;
        for (int i = 0; i < 3; i++) begin
            if (open_drain_c[i]) begin
                c_out_next[i] = 1'b0;
                c_oe_n_next[i] = ~(c_dir_reg[i] & ~c_data_reg[i]);
            end
        end
        if (misc_control_reg[usb_sel_bit]) begin
            c_out_next[port_c_usb_pin] = usb_level_reg;
            c_oe_n_next[port_c_usb_pin] = 1'b0;
        end
        for (int i = 0; i < 3; i++) begin
            irq_next[i] = ext_irq_enable_reg[irq_first_pin + i]
                & pin_level_reg[8 + irq_first_pin + i];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            a_data_reg <= port_reset_value;
            a_dir_reg <= port_reset_value;
            b_data_reg <= port_reset_value;
            b_dir_reg <= port_reset_value;
            c_data_reg <= port_c_reset_value;
            c_dir_reg <= port_c_reset_value;
            misc_control_reg <= port_reset_value;
            ext_irq_enable_reg <= port_reset_value;
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= 3'h0;
            hrdata_reg <= 32'h0000_0000;
            a_out_reg <= port_reset_value;
            a_oe_n_reg <= 8'hff;
            b_out_reg <= port_reset_value;
            b_oe_n_reg <= 8'hff;
            c_out_reg <= port_c_reset_value;
            c_oe_n_reg <= 3'h7;
            irq_reg <= 3'h0;
            pin_level_reg <= '0;
            usb_level_reg <= 1'b0;
        end else begin
            a_data_reg <= a_data_next;
            a_dir_reg <= a_dir_next;
            b_data_reg <= b_data_next;
            b_dir_reg <= b_dir_next;
            c_data_reg <= c_data_next;
            c_dir_reg <= c_dir_next;
            misc_control_reg <= misc_control_next;
            ext_irq_enable_reg <= ext_irq_enable_next;
            wr_pend_reg <= wr_pend_next;
            wr_idx_reg <= wr_idx_next;
            hrdata_reg <= hrdata_next;
            a_out_reg <= a_out_next;
            a_oe_n_reg <= a_oe_n_next;
            b_out_reg <= b_out_next;
            b_oe_n_reg <= b_oe_n_next;
            c_out_reg <= c_out_next;
            c_oe_n_reg <= c_oe_n_next;
            irq_reg <= irq_next;
            pin_level_reg <= pin_level_next;
            usb_level_reg <= usb_level_next;
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign port_a_out = a_out_reg;
    assign port_a_oe_n = a_oe_n_reg;
    assign port_b_out = b_out_reg;
    assign port_b_oe_n = b_oe_n_reg;
    assign port_c_out = c_out_reg;
    assign port_c_oe_n = c_oe_n_reg;
    assign ext_irq_line_six = irq_reg[0];
    assign ext_irq_line_seven = irq_reg[1];
    assign ext_irq_line_eight = irq_reg[2];

    property p_write_latch;
        @(posedge clock) disable iff (reset)
        wr_pend_reg && wr_idx_reg == port_a_data_idx |=> a_data_reg == $past(hwdata[7:0]);
    endproperty
    a_write_latch: assert property (p_write_latch) else $error("port a latch missed write");

    property p_read_mux;
        @(posedge clock) disable iff (reset)
        take && !hwrite && haddr[31:2] == 30'h0000_0000
            |=> hrdata_reg[7:0] == $past(a_read) && hrdata_reg[31:8] == 24'h00_0000;
    endproperty
    a_read_mux: assert property (p_read_mux) else $error("port a readback wrong");

    property p_open_drain;
        @(posedge clock) disable iff (reset)
        1'b1 |-> ((a_read & open_drain_a) == (pin_level_reg[7:0] & open_drain_a));
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain readback wrong");

    property p_port_c_width;
        @(posedge clock) disable iff (reset)
        take && !hwrite && haddr[4:2] == port_c_data_idx && haddr[31:5] == 27'h000_0000
            |=> hrdata_reg[31:3] == 29'h0000_0000;
    endproperty
    a_port_c_width: assert property (p_port_c_width) else $error("port c upper bits set");

    property p_direction;
        @(posedge clock) disable iff (reset)
        ##1 (b_oe_n_reg & ~open_drain_b) == (~$past(b_dir_reg) & ~open_drain_b);
    endproperty
    a_direction: assert property (p_direction) else $error("direction not applied");

    property p_reset_clear;
        @(posedge clock) $past(reset) |-> a_dir_reg == 8'h00 && c_data_reg == 3'h0
            && b_dir_reg == 8'h00 && port_a_oe_n == 8'hff;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear");

    property p_irq_feed;
        @(posedge clock) disable iff (reset)
        !ext_irq_enable_reg[irq_first_pin] |=> !ext_irq_line_six;
    endproperty
    a_irq_feed: assert property (p_irq_feed) else $error("irq line high while disabled");

    property p_usb_pin;
        @(posedge clock) disable iff (reset)
        misc_control_reg[usb_sel_bit] |=> !port_c_oe_n[port_c_usb_pin]
            && port_c_out[port_c_usb_pin] == $past(usb_level_reg);
    endproperty
    a_usb_pin: assert property (p_usb_pin) else $error("usb indication not on pin");

    property p_always_ready;
        @(posedge clock) disable iff (reset)
        take |=> hreadyout && !hresp;
    endproperty
    a_always_ready: assert property (p_always_ready) else $error("slave stalled");
endmodule : byte_wide_io_ports

/* File: logic/gpio_ports_pkg.sv */
package gpio_ports_pkg;
    // printed offsets are not multiples of four: they are indices, byte address = 4 * index
    localparam logic [2:0] port_a_data_idx = 3'h0;
    localparam logic [2:0] port_a_direction_idx = 3'h1;
    localparam logic [2:0] port_b_data_idx = 3'h2;
    localparam logic [2:0] port_b_direction_idx = 3'h3;
    localparam logic [2:0] port_c_data_idx = 3'h4;
    localparam logic [2:0] port_c_direction_idx = 3'h5;
    localparam logic [2:0] misc_control_idx = 3'h6;
    localparam logic [2:0] ext_irq_enable_idx = 3'h7;
    localparam logic [7:0] port_reset_value = 8'h00;
    localparam logic [2:0] port_c_reset_value = 3'h0;
    localparam logic [7:0] port_c_mask = 8'h07;
    localparam int usb_sel_bit = 1;
    localparam int irq_first_pin = 5;
    localparam int port_c_usb_pin = 2;
    localparam logic [1:0] htrans_nonseq = 2'b10;
    localparam logic [2:0] hsize_word = 3'b010;
endpackage : gpio_ports_pkg

/* File: tb/ext_pins.sv */
`timescale 1ns/1ps
module ext_pins (
    // device drive side
    input wire logic [7:0] a_out,
    input wire logic [7:0] a_oe_n,
    input wire logic [7:0] b_out,
    input wire logic [7:0] b_oe_n,
    input wire logic [2:0] c_out,
    input wire logic [2:0] c_oe_n,
    // levels held from outside
    input wire logic [7:0] ext_a,
    input wire logic [7:0] ext_b,
    input wire logic [2:0] ext_c,
    input wire logic [2:0] ext_c_en,
    // resolved pin levels
    output logic [7:0] a_in,
    output logic [7:0] b_in,
    output logic [2:0] c_in
);
    // a and b have no pull-up, so an outside driver always holds a level
    assign a_in = (a_out & ~a_oe_n) | (ext_a & a_oe_n);
    assign b_in = (b_out & ~b_oe_n) | (ext_b & b_oe_n);
    // port c floats high through its pull-up
    assign c_in = (c_out & ~c_oe_n) | (c_oe_n & ((ext_c & ext_c_en) | ~ext_c_en));
endmodule : ext_pins

/* File: tb/tb_byte_wide_io_ports.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("unexpected %s exp %h got %h", nm, exp, got); end end
module tb_byte_wide_io_ports;
    import gpio_ports_pkg::*;
    logic clock = 0;
    logic reset = 1;
    logic hsel = 0, hwrite = 0, usb_transmitting = 0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = hsize_word;
    logic hready, hreadyout, hresp, six, seven, eight;
    logic [7:0] a_in, a_out, a_oe_n, b_in, b_out, b_oe_n, ext_a = '0, ext_b = '0;
    logic [2:0] c_in, c_out, c_oe_n, irq, ext_c = '0, ext_c_en = 3'h7;
    int n_mismatch = 0, num_checks = 0;
    assign hready = hreadyout;
    assign irq = {six, seven, eight};
    initial begin
        forever #4 clock = ~clock;
    end
    byte_wide_io_ports #(.open_drain_a(8'h01)) dut (.clock(clock), .reset(reset),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .port_a_in(a_in), .port_a_out(a_out), .port_a_oe_n(a_oe_n),
        .port_b_in(b_in), .port_b_out(b_out), .port_b_oe_n(b_oe_n), .port_c_in(c_in),
        .port_c_out(c_out), .port_c_oe_n(c_oe_n), .usb_transmitting(usb_transmitting),
        .ext_irq_line_six(six), .ext_irq_line_seven(seven), .ext_irq_line_eight(eight));
    ext_pins pins (.a_out(a_out), .a_oe_n(a_oe_n), .b_out(b_out), .b_oe_n(b_oe_n),
        .c_out(c_out), .c_oe_n(c_oe_n), .ext_a(ext_a), .ext_b(ext_b), .ext_c(ext_c),
        .ext_c_en(ext_c_en), .a_in(a_in), .b_in(b_in), .c_in(c_in));

    task automatic summarize();
        $display("mismatches %0d checks %0d", n_mismatch, num_checks);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    task automatic wait_ready();
        for (int i = 0; i < 16; i++) begin
            @(posedge clock);
            if (hreadyout === 1'b1) return;
        end
        n_mismatch++;
        summarize();
    endtask : wait_ready

    // hold the address phase until hready, then the data phase until hready
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= htrans_nonseq;
        haddr <= addr;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : bus

    // idle edge first: a read right behind a write of the same place sees old data
    task automatic rchk(input string nm, input logic [31:0] addr, input logic [31:0] exp);
        @(posedge clock);
        bus(1'b0, addr, 32'h0000_0000);
        `CHK(nm, exp, rd)
    endtask : rchk

    // pins pass a three-flop sync before they show
    task automatic settle();
        repeat (6) @(posedge clock);
    endtask : settle

    task automatic reset_values();
        for (int i = 0; i < 6; i++) begin
            rchk("reset reg", 32'(4 * i), 32'h0000_0000);
        end
        `CHK("a oe_n", 8'hff, a_oe_n)
        `CHK("c oe_n", 3'h7, c_oe_n)
    endtask : reset_values

    task automatic data_and_direction();
        ext_a <= 8'h3c;
        bus(1'b1, 32'h0000_0000, 32'h0000_00a5);
        settle();
        rchk("a input", 32'h0000_0000, 32'h0000_003c);
        bus(1'b1, 32'h0000_0004, 32'h0000_00f0);
        rchk("a dir", 32'h0000_0004, 32'h0000_00f0);
        rchk("a mixed", 32'h0000_0000, 32'h0000_00ac);
        `CHK("a out", 4'ha, a_out[7:4])
        `CHK("a oe_n", 8'h0f, a_oe_n)
        bus(1'b1, 32'h0000_0004, 32'h0000_00f1);
        settle();
        rchk("a open drain", 32'h0000_0000, 32'h0000_00ac);
        `CHK("a od oe_n", 8'h0f, a_oe_n)
        bus(1'b1, 32'h0000_0000, 32'h0000_00a4);
        settle();
        `CHK("a od drive", 8'h0e, a_oe_n)
        rchk("a od low", 32'h0000_0000, 32'h0000_00ac);
    endtask : data_and_direction

    // latch written while still input, then half the pins turned to outputs
    task automatic port_b_pins();
        ext_b <= 8'h5a;
        bus(1'b1, 32'h0000_0008, 32'h0000_0096);
        `CHK("hresp", 1'b0, hresp)
        bus(1'b1, 32'h0000_000c, 32'h0000_000f);
        settle();
        rchk("b dir", 32'h0000_000c, 32'h0000_000f);
        rchk("b mixed", 32'h0000_0008, 32'h0000_0056);
        `CHK("b out", 8'h96, b_out)
        `CHK("b oe_n", 8'hf0, b_oe_n)
        `CHK("irq idle", 3'b000, irq)
    endtask : port_b_pins

    task automatic port_c_width();
        bus(1'b1, 32'h0000_0014, 32'h0000_00ff);
        bus(1'b1, 32'h0000_0010, 32'h0000_00ff);
        rchk("c dir", 32'h0000_0014, 32'h0000_0007);
        rchk("c data", 32'h0000_0010, 32'h0000_0007);
        rchk("unmapped", 32'h0000_0020, 32'h0000_0000);
        bus(1'b1, 32'h0000_0014, 32'h0000_0000);
        ext_c <= 3'h1;
        ext_c_en <= 3'h5;
        settle();
        rchk("c pins", 32'h0000_0010, 32'h0000_0003);
    endtask : port_c_width

    task automatic irq_lines();
        ext_b <= 8'ha0;
        bus(1'b1, 32'h0000_001c, 32'h0000_00e0);
        settle();
        `CHK("irq", 3'b101, irq)
        ext_b <= 8'h40;
        settle();
        `CHK("irq", 3'b010, irq)
        bus(1'b1, 32'h0000_001c, 32'h0000_0000);
        settle();
        `CHK("irq off", 3'b000, irq)
    endtask : irq_lines

    task automatic usb_select();
        bus(1'b1, 32'h0000_0014, 32'h0000_0004);
        bus(1'b1, 32'h0000_0010, 32'h0000_0000);
        bus(1'b1, 32'h0000_0018, 32'h0000_0002);
        usb_transmitting <= 1'b1;
        settle();
        `CHK("usb pin", 1'b1, c_out[2])
        `CHK("usb oe_n", 1'b0, c_oe_n[2])
        usb_transmitting <= 1'b0;
        settle();
        `CHK("usb pin", 1'b0, c_out[2])
        bus(1'b1, 32'h0000_0018, 32'h0000_0000);
        usb_transmitting <= 1'b1;
        settle();
        `CHK("usb off", 1'b0, c_out[2])
    endtask : usb_select

    initial begin
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        reset_values();
        data_and_direction();
        port_b_pins();
        port_c_width();
        irq_lines();
        usb_select();
        summarize();
    end
endmodule : tb_byte_wide_io_ports
